// *** debug_port_mailbox.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "debug_port_mailbox_map.svh"

// ****************************************
// Synchronous FIFO
// ****************************************
module mbx_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;
   assign in_ready_o = (count_r != (AW+1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o = mem_r[rptr_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_r[wptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : mbx_fifo

// ****************************************
// Mailbox top
// ****************************************
module debug_port_mailbox #(
   parameter int FIFO_DEPTH = `MBX_FIFO_DEPTH
) (
   // System clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Processor register port
   input wire debug_port_mailbox_pkg::cpu_req_s cpu_req_i,
   output logic [15:0] cpu_rdata_o,
   output logic cpu_rvalid_o,
   // Test port side, link clock domain
   input wire logic clk_link_i,
   input wire logic in_wr_valid_i,
   input wire debug_port_mailbox_pkg::mbx_word_s in_wr_word_i,
   output logic in_wr_ready_o,
   input wire logic out_rd_valid_i,
   input wire logic out_rd_chan_i,
   output logic out_rd_ready_o,
   output logic out_rd_done_o,
   output logic [15:0] out_rd_data_o
);
   import debug_port_mailbox_pkg::*;
   // Upper byte written, by a word access or by a byte access.
   function automatic logic upper_written(input cpu_req_s r, input logic [2:0] idx);
      upper_written = r.wr && (r.idx == idx) && r.be[1];
   endfunction : upper_written
   function automatic logic [15:0] merge(input logic [15:0] old, input cpu_req_s r);
      merge = {r.be[1] ? r.wdata[15:8] : old[15:8], r.be[0] ? r.wdata[7:0] : old[7:0]};
   endfunction : merge
   // ****************************************
   // Link domain
   // ****************************************
   logic lrst_m_r;
   logic lrst_b_r;
   mbx_word_s wr_hold_r;
   logic wr_tgl_r;
   logic wr_ack_m_r;
   logic wr_ack_s_r;
   logic rd_tgl_r;
   logic rd_chan_hold_r;
   logic rd_ack_m_r;
   logic rd_ack_s_r;
   logic rd_ack_seen_r;
   // Sys-domain handshake state, declared early for the link side.
   logic wr_ack_tgl_r;
   logic rd_ack_tgl_r;
   logic [15:0] resp_data_r;
   // The system reset is carried into the link domain through two stages.
   always_ff @(posedge clk_link_i) begin
      lrst_m_r <= rst_b_i;
      lrst_b_r <= lrst_m_r;
   end
   always_ff @(posedge clk_link_i) begin
      wr_ack_m_r <= wr_ack_tgl_r;
      wr_ack_s_r <= wr_ack_m_r;
      rd_ack_m_r <= rd_ack_tgl_r;
      rd_ack_s_r <= rd_ack_m_r;
   end
   // One incoming word in flight; the hold register stays still until acknowledged.
   assign in_wr_ready_o = lrst_b_r && (wr_tgl_r == wr_ack_s_r);
   always_ff @(posedge clk_link_i) begin
      if (!lrst_b_r) begin
         wr_tgl_r <= 1'b0;
         wr_hold_r <= '0;
      end else if (in_wr_valid_i && in_wr_ready_o) begin
         wr_hold_r <= in_wr_word_i;
         wr_tgl_r <= ~wr_tgl_r;
      end
   end
   assign out_rd_ready_o = lrst_b_r && (rd_tgl_r == rd_ack_seen_r);
   always_ff @(posedge clk_link_i) begin
      if (!lrst_b_r) begin
         rd_tgl_r <= 1'b0;
         rd_chan_hold_r <= 1'b0;
      end else if (out_rd_valid_i && out_rd_ready_o) begin
         rd_chan_hold_r <= out_rd_chan_i;
         rd_tgl_r <= ~rd_tgl_r;
      end
   end
   // The response word is held steady by the system side until the next request.
   always_ff @(posedge clk_link_i) begin
      if (!lrst_b_r) begin
         rd_ack_seen_r <= 1'b0;
         out_rd_done_o <= 1'b0;
         out_rd_data_o <= `MBX_RST_MSG;
      end else begin
         out_rd_done_o <= (rd_ack_s_r != rd_ack_seen_r);
         if (rd_ack_s_r != rd_ack_seen_r) begin
            rd_ack_seen_r <= rd_ack_s_r;
            out_rd_data_o <= resp_data_r;
         end
      end
   end

   // ****************************************
   // System domain crossing
   // ****************************************
   logic wr_tgl_m_r;
   logic wr_tgl_s_r;
   logic rd_tgl_m_r;
   logic rd_tgl_s_r;
   logic fifo_in_ready;
   logic fifo_push;
   logic fifo_valid;
   logic fifo_pop;
   mbx_word_s fifo_word;
   logic rd_req;
   always_ff @(posedge clk_sys_i) begin
      wr_tgl_m_r <= wr_tgl_r;
      wr_tgl_s_r <= wr_tgl_m_r;
      rd_tgl_m_r <= rd_tgl_r;
      rd_tgl_s_r <= rd_tgl_m_r;
   end
   // A full FIFO withholds the acknowledge, which stalls the test port.
   assign fifo_push = (wr_tgl_s_r != wr_ack_tgl_r) && fifo_in_ready;
   assign rd_req = (rd_tgl_s_r != rd_ack_tgl_r);
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wr_ack_tgl_r <= 1'b0;
      end else if (fifo_push) begin
         wr_ack_tgl_r <= ~wr_ack_tgl_r;
      end
   end
   mbx_fifo #(
      .WIDTH($bits(mbx_word_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(wr_hold_r),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_word)
   );

   // ****************************************
   // Mailbox registers
   // ****************************************
   logic [15:0] in_msg_r [2];
   logic [15:0] out_msg_r [2];
   logic [1:0] in_flag_r;
   logic [1:0] out_flag_r;
   logic width_sel_r;
   logic [1:0] in_acd_r;
   logic ctrl_wr;
   logic [1:0] in_load;
   logic [1:0] in_rd;
   logic [1:0] out_host_rd;
   logic [15:0] ctrl_val;
   // Narrow mode drops words addressed to channel 1.
   assign fifo_pop = fifo_valid && (!in_flag_r[fifo_word.chan] || (fifo_word.chan && !width_sel_r));
   assign in_load[0] = fifo_pop && !fifo_word.chan;
   assign in_load[1] = fifo_pop && fifo_word.chan && width_sel_r;
   assign in_rd[0] = cpu_req_i.rd && (cpu_req_i.idx == `MBX_IDX_IN0);
   assign in_rd[1] = cpu_req_i.rd && (cpu_req_i.idx == `MBX_IDX_IN1);
   assign out_host_rd[0] = rd_req && !rd_chan_hold_r;
   assign out_host_rd[1] = rd_req && rd_chan_hold_r;
   assign ctrl_wr = cpu_req_i.wr && (cpu_req_i.idx == `MBX_IDX_CTRL) && cpu_req_i.be[0];

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         in_msg_r[0] <= `MBX_RST_MSG;
         in_msg_r[1] <= `MBX_RST_MSG;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (in_load[c]) begin
               in_msg_r[c] <= fifo_word.data;
            end
         end
      end
   end
   // Software may write the incoming flags; a new arrival in the same cycle wins.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         in_flag_r <= {2{`MBX_RST_IN_FLAG}};
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (in_load[c]) begin
               in_flag_r[c] <= 1'b1;
            end else if (ctrl_wr) begin
               in_flag_r[c] <= cpu_req_i.wdata[`MBX_BIT_IN0_FLAG + c];
            end else if (in_rd[c] && !in_acd_r[c]) begin
               in_flag_r[c] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         out_msg_r[0] <= `MBX_RST_MSG;
         out_msg_r[1] <= `MBX_RST_MSG;
      end else begin
         if (cpu_req_i.wr && (cpu_req_i.idx == `MBX_IDX_OUT0)) begin
            out_msg_r[0] <= merge(out_msg_r[0], cpu_req_i);
         end
         if (cpu_req_i.wr && (cpu_req_i.idx == `MBX_IDX_OUT1)) begin
            out_msg_r[1] <= merge(out_msg_r[1], cpu_req_i);
         end
      end
   end
   // A host read finishing in the cycle of a processor write leaves the flag set.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         out_flag_r <= {2{`MBX_RST_OUT_FLAG}};
      end else begin
         if (out_host_rd[0]) begin
            out_flag_r[0] <= 1'b1;
         end else if (upper_written(cpu_req_i, `MBX_IDX_OUT0)) begin
            out_flag_r[0] <= 1'b0;
         end
         if (out_host_rd[1]) begin
            out_flag_r[1] <= 1'b1;
         end else if (upper_written(cpu_req_i, `MBX_IDX_OUT1)) begin
            out_flag_r[1] <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         rd_ack_tgl_r <= 1'b0;
         resp_data_r <= `MBX_RST_MSG;
      end else if (rd_req) begin
         rd_ack_tgl_r <= ~rd_ack_tgl_r;
         resp_data_r <= out_msg_r[rd_chan_hold_r];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         width_sel_r <= `MBX_RST_CTRL_BIT;
         in_acd_r <= {2{`MBX_RST_CTRL_BIT}};
      end else if (ctrl_wr) begin
         width_sel_r <= cpu_req_i.wdata[`MBX_BIT_WIDTH_SEL];
         in_acd_r[0] <= cpu_req_i.wdata[`MBX_BIT_IN0_ACD];
         in_acd_r[1] <= cpu_req_i.wdata[`MBX_BIT_IN1_ACD];
      end
   end

   // ****************************************
   // Processor read data
   // ****************************************
   always_comb begin
      ctrl_val = '0;
      ctrl_val[`MBX_BIT_IN0_FLAG] = in_flag_r[0];
      ctrl_val[`MBX_BIT_IN1_FLAG] = in_flag_r[1];
      ctrl_val[`MBX_BIT_OUT0_FLAG] = out_flag_r[0];
      ctrl_val[`MBX_BIT_OUT1_FLAG] = out_flag_r[1];
      ctrl_val[`MBX_BIT_WIDTH_SEL] = width_sel_r;
      ctrl_val[`MBX_BIT_RESERVED] = 1'b0;
      ctrl_val[`MBX_BIT_IN0_ACD] = in_acd_r[0];
      ctrl_val[`MBX_BIT_IN1_ACD] = in_acd_r[1];
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         cpu_rdata_o <= '0;
         cpu_rvalid_o <= 1'b0;
      end else begin
         cpu_rvalid_o <= cpu_req_i.rd;
         case (cpu_req_i.idx)
            `MBX_IDX_CTRL: cpu_rdata_o <= ctrl_val;
            `MBX_IDX_IN0: cpu_rdata_o <= in_msg_r[0];
            `MBX_IDX_IN1: cpu_rdata_o <= in_msg_r[1];
            `MBX_IDX_OUT0: cpu_rdata_o <= out_msg_r[0];
            `MBX_IDX_OUT1: cpu_rdata_o <= out_msg_r[1];
            default: cpu_rdata_o <= '0;
         endcase
      end
   end
endmodule : debug_port_mailbox
`default_nettype wire

// *** debug_port_mailbox_map.svh ***
`ifndef DEBUG_PORT_MAILBOX_MAP_SVH
`define DEBUG_PORT_MAILBOX_MAP_SVH

// ****************************************
// Register indices
// ****************************************
`define MBX_IDX_CTRL 3'h0
`define MBX_IDX_IN0 3'h1
`define MBX_IDX_IN1 3'h2
`define MBX_IDX_OUT0 3'h3
`define MBX_IDX_OUT1 3'h4

// ****************************************
// Control register fields
// ****************************************
`define MBX_BIT_IN0_FLAG 0
`define MBX_BIT_IN1_FLAG 1
`define MBX_BIT_OUT0_FLAG 2
`define MBX_BIT_OUT1_FLAG 3
`define MBX_BIT_WIDTH_SEL 4
`define MBX_BIT_RESERVED 5
`define MBX_BIT_IN0_ACD 6
`define MBX_BIT_IN1_ACD 7

// ****************************************
// Reset values and default FIFO depth
// ****************************************
`define MBX_RST_MSG 16'h0000
`define MBX_RST_IN_FLAG 1'b0
`define MBX_RST_OUT_FLAG 1'b1
`define MBX_RST_CTRL_BIT 1'b0
`define MBX_FIFO_DEPTH 32

`endif

// *** debug_port_mailbox_pkg.sv ***
`default_nettype none
package debug_port_mailbox_pkg;

   // Message word as it travels from the test port into the mailbox.
   typedef struct packed {
      logic chan;
      logic [15:0] data;
   } mbx_word_s;

   // Register access from the processor side.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] idx;
      logic [1:0] be;
      logic [15:0] wdata;
   } cpu_req_s;

endpackage : debug_port_mailbox_pkg
`default_nettype wire

// *** debug_port_mailbox_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "debug_port_mailbox_map.svh"
// ********
// Port checker
// ********
module debug_port_mailbox_monitor #(
   parameter int FIFO_DEPTH = 32
) (
   // System side
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire debug_port_mailbox_pkg::cpu_req_s cpu_req_i,
   input wire logic [15:0] cpu_rdata_o,
   input wire logic cpu_rvalid_o,
   // Link side
   input wire logic clk_link_i,
   input wire logic in_wr_valid_i,
   input wire logic in_wr_ready_o,
   input wire logic out_rd_valid_i,
   input wire logic out_rd_ready_o,
   input wire logic out_rd_done_o,
   input wire logic [15:0] out_rd_data_o
);
   import debug_port_mailbox_pkg::*;
   a_rd_answered: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      cpu_req_i.rd |=> cpu_rvalid_o) else $error("Read not answered.");
   a_rvalid_only: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !cpu_req_i.rd |=> !cpu_rvalid_o) else $error("Answer without read.");
   a_ctrl_reserved: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      cpu_req_i.rd && cpu_req_i.idx == `MBX_IDX_CTRL |=> cpu_rdata_o[15:8] == 8'h00 && !cpu_rdata_o[5])
      else $error("Reserved control bits not zero.");
   // A host read wins over a write clear, so only windows with no host read in flight count.
   a_out1_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      cpu_req_i.wr && cpu_req_i.idx == `MBX_IDX_OUT1 && cpu_req_i.be[1] && out_rd_ready_o ##2
      cpu_req_i.rd && cpu_req_i.idx == `MBX_IDX_CTRL && out_rd_ready_o |=> !cpu_rdata_o[3])
      else $error("Outgoing flag 1 not cleared.");
   a_out0_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      cpu_req_i.wr && cpu_req_i.idx == `MBX_IDX_OUT0 && cpu_req_i.be[1] && out_rd_ready_o ##2
      cpu_req_i.rd && cpu_req_i.idx == `MBX_IDX_CTRL && out_rd_ready_o |=> !cpu_rdata_o[2])
      else $error("Outgoing flag 0 not cleared.");
   a_read_served: assert property (@(posedge clk_link_i) disable iff (!rst_b_i)
      out_rd_valid_i && out_rd_ready_o |-> ##[1:30] out_rd_done_o) else $error("Host read not served.");
   a_done_pulse: assert property (@(posedge clk_link_i) disable iff (!rst_b_i)
      out_rd_done_o |=> !out_rd_done_o) else $error("Done longer than one cycle.");
   a_data_hold: assert property (@(posedge clk_link_i) disable iff (!rst_b_i)
      !out_rd_done_o ##1 !out_rd_done_o |-> $stable(out_rd_data_o)) else $error("Read data moved.");
   a_in_ack_drop: assert property (@(posedge clk_link_i) disable iff (!rst_b_i)
      in_wr_valid_i && in_wr_ready_o |=> !in_wr_ready_o) else $error("Ready stayed after take.");
endmodule : debug_port_mailbox_monitor
bind debug_port_mailbox debug_port_mailbox_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o),
   .cpu_rvalid_o(cpu_rvalid_o), .clk_link_i(clk_link_i), .in_wr_valid_i(in_wr_valid_i),
   .in_wr_ready_o(in_wr_ready_o), .out_rd_valid_i(out_rd_valid_i), .out_rd_ready_o(out_rd_ready_o),
   .out_rd_done_o(out_rd_done_o), .out_rd_data_o(out_rd_data_o));
`default_nettype wire

// *** link_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// ********
// Debug host model
// ********
module link_host (
   // Link clock
   input wire logic clk_link_i,
   // Incoming words
   output logic in_wr_valid_o,
   output debug_port_mailbox_pkg::mbx_word_s in_wr_word_o,
   input wire logic in_wr_ready_i,
   // Outgoing reads
   output logic out_rd_valid_o,
   output logic out_rd_chan_o,
   input wire logic out_rd_ready_i,
   input wire logic out_rd_done_i,
   input wire logic [15:0] out_rd_data_i
);
   import debug_port_mailbox_pkg::*;
   initial begin
      in_wr_valid_o = 1'b0;
      in_wr_word_o = '0;
      out_rd_valid_o = 1'b0;
      out_rd_chan_o = 1'b0;
   end
   // Idle lines show the inverse of the last value so nothing stale looks valid.
   task automatic send(input logic ch, input logic [15:0] d, output logic ok);
      ok = 1'b0;
      @(posedge clk_link_i);
      #1 in_wr_valid_o = 1'b1;
      in_wr_word_o = {ch, d};
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge clk_link_i);
         ok = in_wr_ready_i;
      end
      #1 in_wr_valid_o = 1'b0;
      in_wr_word_o = ~in_wr_word_o;
   endtask : send
   task automatic fetch(input logic ch, output logic [15:0] d, output logic ok);
      ok = 1'b0;
      d = 16'h0000;
      @(posedge clk_link_i);
      #1 out_rd_valid_o = 1'b1;
      out_rd_chan_o = ch;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge clk_link_i);
         ok = out_rd_ready_i;
      end
      #1 out_rd_valid_o = 1'b0;
      out_rd_chan_o = ~ch;
      ok = 1'b0;
      for (int n = 0; n < 50 && !ok; n++) begin
         @(posedge clk_link_i);
         ok = out_rd_done_i;
         d = out_rd_data_i;
      end
   endtask : fetch
endmodule : link_host
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "debug_port_mailbox_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
// ********
// Testbench
// ********
module tb;
   import debug_port_mailbox_pkg::*;
   localparam int DEPTH = 4;
   logic clk_sys_i, clk_link_i, rst_b_i, cpu_rvalid_o, in_wr_valid_i, in_wr_ready_o, ok;
   logic out_rd_valid_i, out_rd_chan_i, out_rd_ready_o, out_rd_done_o;
   logic [15:0] cpu_rdata_o, out_rd_data_o, r;
   cpu_req_s cpu_req_i;
   mbx_word_s in_wr_word_i;
   int n_errors = 0, num_checks = 0, i, j, k;
   debug_port_mailbox #(.FIFO_DEPTH(DEPTH)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o), .clk_link_i(clk_link_i),
      .in_wr_valid_i(in_wr_valid_i), .in_wr_word_i(in_wr_word_i), .in_wr_ready_o(in_wr_ready_o),
      .out_rd_valid_i(out_rd_valid_i), .out_rd_chan_i(out_rd_chan_i), .out_rd_ready_o(out_rd_ready_o),
      .out_rd_done_o(out_rd_done_o), .out_rd_data_o(out_rd_data_o));
   link_host host (.clk_link_i(clk_link_i), .in_wr_valid_o(in_wr_valid_i), .in_wr_word_o(in_wr_word_i),
      .in_wr_ready_i(in_wr_ready_o), .out_rd_valid_o(out_rd_valid_i), .out_rd_chan_o(out_rd_chan_i),
      .out_rd_ready_i(out_rd_ready_o), .out_rd_done_i(out_rd_done_o), .out_rd_data_i(out_rd_data_o));
   initial begin clk_sys_i = 0; forever #2 clk_sys_i = ~clk_sys_i; end
   initial begin clk_link_i = 0; #1; forever #3 clk_link_i = ~clk_link_i; end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   task automatic cpu(input logic rd, input logic wr, input logic [2:0] idx, input logic [1:0] be,
      input logic [15:0] wd);
      @(posedge clk_sys_i);
      #1 cpu_req_i = '{rd: rd, wr: wr, idx: idx, be: be, wdata: wd};
      @(posedge clk_sys_i);
      #1 cpu_req_i = '0;
      r = cpu_rdata_o;
      if (rd) `CHK(cpu_rvalid_o, 1'b1)
   endtask : cpu
   task automatic rd(input logic [2:0] idx); cpu(1'b1, 1'b0, idx, 2'h0, 16'h0000); endtask : rd
   task automatic wr(input logic [2:0] idx, input logic [1:0] be, input logic [15:0] d);
      cpu(1'b0, 1'b1, idx, be, d);
   endtask : wr
   // Polling keeps the bench independent of the exact crossing latency.
   task automatic wait_ctrl(input logic [15:0] m);
      for (k = 0; k < 60; k++) begin rd(`MBX_IDX_CTRL); if ((r & m) === m) return; end
      n_errors++;
      $display("MISMATCH t=%0t flag wait timed out", $time);
      end_sim();
   endtask : wait_ctrl
   task automatic snd(input logic ch, input logic [15:0] d);
      host.send(ch, d, ok);
      `CHK(ok, 1'b1)
      if (!ok) end_sim();
   endtask : snd
   task automatic t_reset;
      rd(`MBX_IDX_CTRL); `CHK(r, 16'h000C)
      for (i = 1; i < 8; i++) begin rd(i[2:0]); `CHK(r, 16'h0000) end
      $display("test reset done");
   endtask : t_reset
   task automatic t_out;
      wr(`MBX_IDX_OUT0, 2'h1, 16'h115A); rd(`MBX_IDX_CTRL); `CHK(r, 16'h000C)
      wr(`MBX_IDX_OUT0, 2'h2, 16'hA5FF); rd(`MBX_IDX_CTRL); `CHK(r, 16'h0008)
      wr(`MBX_IDX_OUT1, 2'h2, 16'h3CC3); rd(`MBX_IDX_CTRL); `CHK(r, 16'h0000)
      rd(`MBX_IDX_OUT0); `CHK(r, 16'hA55A)
      rd(`MBX_IDX_OUT1); `CHK(r, 16'h3C00)
      host.fetch(1'b0, r, ok); `CHK({ok, r}, 17'h1A55A)
      if (!ok) end_sim();
      wait_ctrl(16'h0004); `CHK(r, 16'h0004)
      host.fetch(1'b1, r, ok); `CHK({ok, r}, 17'h13C00)
      if (!ok) end_sim();
      wait_ctrl(16'h0008); `CHK(r, 16'h000C)
      $display("test outgoing done");
   endtask : t_out
   task automatic t_in;
      snd(1'b0, 16'h1234); wait_ctrl(16'h0001);
      wr(`MBX_IDX_IN0, 2'h3, 16'hFFFF); rd(`MBX_IDX_IN0); `CHK(r, 16'h1234)
      rd(`MBX_IDX_CTRL); `CHK(r, 16'h000C)
      wr(`MBX_IDX_CTRL, 2'h1, 16'h0040); snd(1'b1, 16'h7777); snd(1'b0, 16'h5678); wait_ctrl(16'h0001);
      rd(`MBX_IDX_IN1); `CHK(r, 16'h0000)
      rd(`MBX_IDX_IN0); `CHK(r, 16'h5678)
      rd(`MBX_IDX_CTRL); `CHK(r, 16'h004D)
      wr(`MBX_IDX_CTRL, 2'h1, 16'h0040); rd(`MBX_IDX_CTRL); `CHK(r, 16'h004C)
      $display("test incoming done");
   endtask : t_in
   task automatic t_wide;
      wr(`MBX_IDX_CTRL, 2'h1, 16'h00B0); rd(`MBX_IDX_CTRL); `CHK(r, 16'h009C)
      snd(1'b0, 16'hAAAA); snd(1'b1, 16'hBBBB); wait_ctrl(16'h0003);
      rd(`MBX_IDX_IN1); `CHK(r, 16'hBBBB)
      rd(`MBX_IDX_IN0); `CHK(r, 16'hAAAA)
      rd(`MBX_IDX_CTRL); `CHK(r, 16'h009E)
      wr(`MBX_IDX_CTRL, 2'h1, 16'h0010); rd(`MBX_IDX_CTRL); `CHK(r, 16'h001C)
      snd(1'b1, 16'hCCCC); wait_ctrl(16'h0002); rd(`MBX_IDX_IN1); `CHK(r, 16'hCCCC)
      rd(`MBX_IDX_CTRL); `CHK(r, 16'h001C)
      $display("test wide done");
   endtask : t_wide
   task automatic t_fill;
      for (i = 0; i < 12 && ok; i++) host.send(1'b0, 16'h0100 + i[15:0], ok);
      `CHK(ok, 1'b0)
      // One word sits in the register, a full FIFO behind it and one at the port, so the next is refused.
      `CHK(i, DEPTH + 3)
      for (j = 0; j < i - 1; j++) begin wait_ctrl(16'h0001); rd(`MBX_IDX_IN0); `CHK(r, 16'h0100 + j[15:0]) end
      rd(`MBX_IDX_CTRL); `CHK(r, 16'h001C)
      $display("test fill done");
   endtask : t_fill
   initial begin
      rst_b_i = 1'b0;
      cpu_req_i = '0;
      ok = 1'b1;
      repeat (12) @(posedge clk_sys_i);
      #1 rst_b_i = 1'b1;
      t_reset();
      t_out();
      t_in();
      t_wide();
      t_fill();
      end_sim();
   end
endmodule : tb
`default_nettype wire
